//--- include/gpio_mux_defs.svh
`ifndef GPIO_MUX_DEFS_SVH
`define GPIO_MUX_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define GPIO_ADDR_W        8
`define GPIO_OFS_DIR       8'h00
`define GPIO_OFS_OUT       8'h04
`define GPIO_OFS_IN        8'h08
`define GPIO_OFS_IRQ_EN    8'h0C
`define GPIO_OFS_POL       8'h10
`define GPIO_OFS_STATUS    8'h14
`define GPIO_OFS_MASK      8'h18
`define GPIO_OFS_GP0_MODE  8'h1C
`define GPIO_OFS_GPEN      8'h20
`define GPIO_OFS_PCI_CTRL  8'h24

// Field positions.
`define GPIO_PINS          16
`define EXT_LSB            4
`define EXT_MSB            7
`define PCI_LSB            9
`define PCI_MSB            15
`define PIN_GP0            0
`define PIN_GP3            3
`define PIN_IDSEL          9
`define PIN_CBE3           10
`define PIN_REQ            11
`define PIN_GNT            12
`define PIN_INTA           13
`define PIN_PCLK           14
`define PIN_PRST           15
`define PCI_CTRL_EN_BIT    0
`define PCI_CTRL_STRAP_BIT 1

// Reset values.
`define RST_PINS           16'h0000
`define RST_NIB            4'h0
`define RST_WORD           32'h0000_0000
`define RST_PCI7           7'h00
`define STRAP_DONE_CNT     2'h3
`define STRAP_CNT_ONE      2'h1
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- include/gpio_mux_pkg.sv
package gpio_mux_pkg;

   // Function of general-purpose pin 0.
   typedef enum logic [1:0] {
      GP0_INPUT,
      GP0_OUTPUT,
      GP0_IRQ
   } gp0_mode_t;

   typedef logic [15:0] pin_vec_t;

endpackage

//--- design/gpio_ext_interrupt_pin_mux.sv
`include "gpio_mux_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module gpio_ext_interrupt_pin_mux
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write channels.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read channels.
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Device pins, split into input, output and active-low enable.
   input  wire logic [15:0] gpio_pin_in,
   output logic [15:0]      gpio_pin_out,
   output logic [15:0]      gpio_pin_oe_n,
   // Configuration strap.
   input  wire logic        pci_enable_strap,
   // Interrupt controller side.
   output logic [3:0]       ext_irq_pulse,
   output logic             irq,
   // PCI core side of the shared pins.
   output logic             pci_reset_in,
   output logic             pci_clock_in,
   output logic             pci_grant_in,
   output logic             pci_idsel_in,
   output logic             pci_byte_en3_in,
   input  wire logic        pci_byte_en3_out,
   input  wire logic        pci_byte_en3_oe,
   input  wire logic        pci_request_out,
   input  wire logic        pci_inta_assert
);

   // Bus state.
   logic                    aw_hold_reg, aw_hold_next;
   logic [7:0]              awaddr_reg, awaddr_next;
   logic                    w_hold_reg, w_hold_next;
   logic [31:0]             wdata_reg, wdata_next;
   logic [3:0]              wstrb_reg, wstrb_next;
   logic                    bvalid_reg, bvalid_next;
   logic [1:0]              bresp_reg, bresp_next;
   logic                    rvalid_reg, rvalid_next;
   logic [31:0]             rdata_reg, rdata_next;
   logic [1:0]              rresp_reg, rresp_next;
   logic                    do_write;
   // Control and status registers.
   logic [15:0]             dir_reg, dir_next;
   logic [15:0]             out_reg, out_next;
   logic [3:0]              interrupt_enable_reg, interrupt_enable_next;
   logic [3:0]              ext_irq_polarity_field_reg;
   logic [3:0]              ext_irq_polarity_field_next;
   logic [3:0]              status_reg, status_next;
   logic [3:0]              mask_reg, mask_next;
   gpio_mux_pkg::gp0_mode_t gp0_mode_reg, gp0_mode_next;
   logic [6:0]              gpen_reg, gpen_next;
   logic                    pci_func_en_reg, pci_func_en_next;
   // Pin synchronisers, strap capture and pin drive.
   logic [15:0]             sync1_reg, sync2_reg;
   logic [3:0]              prev_reg;
   logic [3:0]              ext_irq_evt;
   logic [1:0]              strap_cnt_reg, strap_cnt_next;
   logic                    strap_reg, strap_next;
   logic                    pci_active;
   logic [15:0]             pin_out_next, pin_oe_n_next;
   logic                    pci_strap_sync1, pci_strap_sync2;

   // Merges new write data into an old word under the byte strobes.
   function automatic logic [31:0] apply_strb(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Tells whether an address names one of the registers.
   function automatic logic reg_hit(input logic [7:0] addr);
      unique case (addr)
         `GPIO_OFS_DIR, `GPIO_OFS_OUT, `GPIO_OFS_IN, `GPIO_OFS_IRQ_EN,
         `GPIO_OFS_POL, `GPIO_OFS_STATUS, `GPIO_OFS_MASK,
         `GPIO_OFS_GP0_MODE, `GPIO_OFS_GPEN, `GPIO_OFS_PCI_CTRL:
            return 1'b1;
         default:
            return 1'b0;
      endcase
   endfunction

   // Channel handshakes: each channel is ready while its holder is empty.
   assign s_axi_awready = ~aw_hold_reg;
   assign s_axi_wready  = ~w_hold_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign do_write      = aw_hold_reg & w_hold_reg & ~bvalid_reg;

   // Bus next state: address and data are taken in either order.
   always_comb
   begin
      aw_hold_next = aw_hold_reg;
      awaddr_next  = awaddr_reg;
      w_hold_next  = w_hold_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      if (s_axi_awvalid && !aw_hold_reg)
      begin
         aw_hold_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg)
      begin
         w_hold_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready)
      begin
         bvalid_next = 1'b0;
      end
      if (do_write)
      begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = reg_hit(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready)
      begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_reg)
      begin
         rvalid_next = 1'b1;
         rresp_next  = reg_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         rdata_next  = `RST_WORD;
         unique case (s_axi_araddr)
            `GPIO_OFS_DIR:      rdata_next[15:0] = dir_reg;
            `GPIO_OFS_OUT:      rdata_next[15:0] = out_reg;
            `GPIO_OFS_IN:       rdata_next[15:0] = sync2_reg;
            `GPIO_OFS_IRQ_EN:
               rdata_next[`EXT_MSB:`EXT_LSB] = interrupt_enable_reg;
            `GPIO_OFS_POL:      rdata_next[3:0] = ext_irq_polarity_field_reg;
            `GPIO_OFS_STATUS:   rdata_next[3:0] = status_reg;
            `GPIO_OFS_MASK:     rdata_next[3:0] = mask_reg;
            `GPIO_OFS_GP0_MODE: rdata_next[1:0] = gp0_mode_reg;
            `GPIO_OFS_GPEN:     rdata_next[`PCI_MSB:`PCI_LSB] = gpen_reg;
            `GPIO_OFS_PCI_CTRL:
            begin
               rdata_next[`PCI_CTRL_EN_BIT]    = pci_func_en_reg;
               rdata_next[`PCI_CTRL_STRAP_BIT] = strap_reg;
            end
            default:            rdata_next = `RST_WORD;
         endcase
      end
   end

   // Bus registers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         awaddr_reg  <= `GPIO_OFS_DIR;
         w_hold_reg  <= 1'b0;
         wdata_reg   <= `RST_WORD;
         wstrb_reg   <= `RST_NIB;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= `RST_WORD;
         rresp_reg   <= `RESP_OKAY;
      end
      else
      begin
         aw_hold_reg <= aw_hold_next;
         awaddr_reg  <= awaddr_next;
         w_hold_reg  <= w_hold_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   // Edge detection on the synchronised interrupt pins.
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         ext_irq_evt[i] = interrupt_enable_reg[i]
            & (ext_irq_polarity_field_reg[i]
               ? (prev_reg[i] & ~sync2_reg[`EXT_LSB + i])
               : (~prev_reg[i] & sync2_reg[`EXT_LSB + i]));
      end
   end

   assign ext_irq_pulse = ext_irq_evt;
   assign irq           = |(status_reg & mask_reg);
   assign pci_active    = strap_reg & pci_func_en_reg;

   // Register writes; a status bit set by an event wins over its clear.
   always_comb
   begin
      logic [31:0] wv;
      wv = `RST_WORD;
      dir_next                    = dir_reg;
      out_next                    = out_reg;
      interrupt_enable_next       = interrupt_enable_reg;
      ext_irq_polarity_field_next = ext_irq_polarity_field_reg;
      status_next                 = status_reg;
      mask_next                   = mask_reg;
      gp0_mode_next               = gp0_mode_reg;
      gpen_next                   = gpen_reg;
      pci_func_en_next            = pci_func_en_reg;
      if (do_write)
      begin
         wv = apply_strb(`RST_WORD, wdata_reg, wstrb_reg);
         unique case (awaddr_reg)
            `GPIO_OFS_DIR:
               dir_next = 16'(apply_strb({16'h0000, dir_reg}, wdata_reg,
                                         wstrb_reg));
            `GPIO_OFS_OUT:
               out_next = 16'(apply_strb({16'h0000, out_reg}, wdata_reg,
                                         wstrb_reg));
            `GPIO_OFS_IRQ_EN:
               if (wstrb_reg[0])
               begin
                  interrupt_enable_next = wdata_reg[`EXT_MSB:`EXT_LSB];
               end
            `GPIO_OFS_POL:
               if (wstrb_reg[0])
               begin
                  ext_irq_polarity_field_next = wdata_reg[3:0];
               end
            `GPIO_OFS_STATUS:
               status_next = status_reg & ~wv[3:0];
            `GPIO_OFS_MASK:
               if (wstrb_reg[0])
               begin
                  mask_next = wdata_reg[3:0];
               end
            `GPIO_OFS_GP0_MODE:
               if (wstrb_reg[0])
               begin
                  gp0_mode_next = gpio_mux_pkg::gp0_mode_t'(wdata_reg[1:0]);
               end
            `GPIO_OFS_GPEN:
               gpen_next = 7'(apply_strb({16'h0000, gpen_reg, 9'h000},
                                         wdata_reg,
                                         wstrb_reg) >> `PCI_LSB);
            `GPIO_OFS_PCI_CTRL:
               if (wstrb_reg[0])
               begin
                  pci_func_en_next = wdata_reg[`PCI_CTRL_EN_BIT];
               end
            default:
               status_next = status_reg;
         endcase
      end
      status_next = status_next | ext_irq_evt;
   end

   // Control registers; all pins start as inputs with no function.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dir_reg                    <= `RST_PINS;
         out_reg                    <= `RST_PINS;
         interrupt_enable_reg       <= `RST_NIB;
         ext_irq_polarity_field_reg <= `RST_NIB;
         status_reg                 <= `RST_NIB;
         mask_reg                   <= `RST_NIB;
         gp0_mode_reg               <= gpio_mux_pkg::GP0_INPUT;
         gpen_reg                   <= `RST_PCI7;
         pci_func_en_reg            <= 1'b0;
      end
      else
      begin
         dir_reg                    <= dir_next;
         out_reg                    <= out_next;
         interrupt_enable_reg       <= interrupt_enable_next;
         ext_irq_polarity_field_reg <= ext_irq_polarity_field_next;
         status_reg                 <= status_next;
         mask_reg                   <= mask_next;
         gp0_mode_reg               <= gp0_mode_next;
         gpen_reg                   <= gpen_next;
         pci_func_en_reg            <= pci_func_en_next;
      end
   end

   // Pin drive: muxes GPIO, interrupt inputs and PCI onto the pins.
   always_comb
   begin
      pin_out_next  = out_reg;
      pin_oe_n_next = ~dir_reg;
      pin_oe_n_next[`EXT_MSB:`EXT_LSB] = ~dir_reg[`EXT_MSB:`EXT_LSB]
                                         | interrupt_enable_reg;
      unique case (gp0_mode_reg)
         gpio_mux_pkg::GP0_OUTPUT:
            pin_oe_n_next[`PIN_GP0] = 1'b0;
         gpio_mux_pkg::GP0_IRQ:
         begin
            pin_out_next[`PIN_GP0]  = irq;
            pin_oe_n_next[`PIN_GP0] = 1'b0;
         end
         default:
            pin_oe_n_next[`PIN_GP0] = 1'b1;
      endcase
      for (int p = `PCI_LSB; p <= `PCI_MSB; p++)
      begin
         if (pci_active || !gpen_reg[p - `PCI_LSB])
         begin
            pin_out_next[p]  = 1'b0;
            pin_oe_n_next[p] = 1'b1;
         end
      end
      if (pci_active)
      begin
         pin_out_next[`PIN_REQ]   = pci_request_out;
         pin_oe_n_next[`PIN_REQ]  = 1'b0;
         pin_oe_n_next[`PIN_INTA] = ~pci_inta_assert;
         pin_out_next[`PIN_CBE3]  = pci_byte_en3_out;
         pin_oe_n_next[`PIN_CBE3] = ~pci_byte_en3_oe;
      end
   end

   // Strap capture counts a few cycles after reset, then freezes.
   always_comb
   begin
      strap_cnt_next = strap_cnt_reg;
      strap_next     = strap_reg;
      if (strap_cnt_reg != `STRAP_DONE_CNT)
      begin
         strap_cnt_next = 2'(strap_cnt_reg + `STRAP_CNT_ONE);
         strap_next     = pci_strap_sync2;
      end
   end

   // Synchronisers, strap, pin outputs and PCI inputs.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_reg       <= `RST_PINS;
         sync2_reg       <= `RST_PINS;
         prev_reg        <= `RST_NIB;
         pci_strap_sync1 <= 1'b0;
         pci_strap_sync2 <= 1'b0;
         strap_cnt_reg   <= 2'h0;
         strap_reg       <= 1'b0;
         gpio_pin_out    <= `RST_PINS;
         gpio_pin_oe_n   <= 16'hFFFF;
         pci_reset_in    <= 1'b0;
         pci_clock_in    <= 1'b0;
         pci_grant_in    <= 1'b0;
         pci_idsel_in    <= 1'b0;
         pci_byte_en3_in <= 1'b0;
      end
      else
      begin
         sync1_reg       <= gpio_pin_in;
         sync2_reg       <= sync1_reg;
         prev_reg        <= sync2_reg[`EXT_MSB:`EXT_LSB];
         pci_strap_sync1 <= pci_enable_strap;
         pci_strap_sync2 <= pci_strap_sync1;
         strap_cnt_reg   <= strap_cnt_next;
         strap_reg       <= strap_next;
         gpio_pin_out    <= pin_out_next;
         gpio_pin_oe_n   <= pin_oe_n_next;
         pci_reset_in    <= pci_active & sync2_reg[`PIN_PRST];
         pci_clock_in    <= pci_active & sync2_reg[`PIN_PCLK];
         pci_grant_in    <= pci_active & sync2_reg[`PIN_GNT];
         pci_idsel_in    <= pci_active & sync2_reg[`PIN_IDSEL];
         pci_byte_en3_in <= pci_active & sync2_reg[`PIN_CBE3];
      end
   end

   // Checks on the behaviour above.
   pins_reset_input_a: assert property (@(posedge aclk)
      $rose(aresetn) |-> &gpio_pin_oe_n[`EXT_MSB:`EXT_LSB])
      else $error("Interrupt pins drive right after reset.");

   irq_pin_input_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ##1 &(~$past(interrupt_enable_reg) | gpio_pin_oe_n[`EXT_MSB:`EXT_LSB]))
      else $error("Enabled interrupt pin is driven.");

   edge_event_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ext_irq_pulse[0] |-> sync2_reg[`EXT_LSB] != $past(sync2_reg[`EXT_LSB]))
      else $error("Interrupt event without a pin edge.");

   edge_polarity_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ext_irq_evt[0] |-> sync2_reg[`EXT_LSB] == ~ext_irq_polarity_field_reg[0])
      else $error("Interrupt event on the wrong edge.");

   pin15_idle_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !$past(pci_active) && !$past(gpen_reg[`PIN_PRST - `PCI_LSB]) |->
         gpio_pin_oe_n[`PIN_PRST] && !pci_reset_in)
      else $error("Pin 15 active while no function is chosen.");

   pci_pins_idle_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !pci_active [*2] |-> !pci_clock_in && !pci_grant_in && !pci_idsel_in)
      else $error("PCI input forwarded while PCI is off.");

   gpio3_input_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ##1 !$past(dir_reg[`PIN_GP3]) |-> gpio_pin_oe_n[`PIN_GP3])
      else $error("Pin 3 drives while set as input.");

   strap_frozen_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      strap_cnt_reg == `STRAP_DONE_CNT |=> $stable(strap_reg))
      else $error("Strap changed after capture.");

   gp0_irq_out_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      gp0_mode_reg == gpio_mux_pkg::GP0_IRQ ##1
         gp0_mode_reg == gpio_mux_pkg::GP0_IRQ |->
         gpio_pin_out[`PIN_GP0] == $past(irq) && !gpio_pin_oe_n[`PIN_GP0])
      else $error("Pin 0 does not carry the interrupt.");

   one_event_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ext_irq_evt[0] |=> !ext_irq_evt[0] && status_reg[0])
      else $error("Edge gave no single latched event.");

endmodule

`default_nettype wire

//--- test/board_model.sv
`timescale 1ns/1ps
`default_nettype none

module board_model
(
   // Pin side of the device.
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe_n,
   // What the board itself puts on the pins.
   input  wire logic [15:0] drive_en,
   input  wire logic [15:0] drive_lvl,
   // Resolved wire level seen by the device.
   output logic      [15:0] pin_in
);
   // Pins 4 to 7 carry pull-ups and all other pins pull-downs.
   localparam logic [15:0] PULL_UP = 16'h00F0;

   // The device driver wins, then the board, and an idle wire takes its pull.
   always_comb
   begin
      for (int i = 0; i < 16; i++)
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] :
                     drive_en[i] ? drive_lvl[i] : PULL_UP[i];
   end
endmodule

`default_nettype wire

//--- test/gpio_ext_interrupt_pin_mux_bench.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_ext_interrupt_pin_mux_bench;
   typedef struct packed {logic [7:0] a; logic [31:0] d, q;
                          logic [1:0] r;} row_t;
   logic        aclk = 1'b0, aresetn = 1'b0, strap = 1'b0, req = 1'b0;
   logic        inta = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, q;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
   logic        arready, rvalid, irq, p_rst, p_clk, p_gnt, p_ids, p_cbe;
   logic [1:0]  bresp, rresp, rsp;
   logic [15:0] pin_in, pin_out, oe_n, den = 16'h0000, dlvl = 16'h0000;
   logic [3:0]  pulse;
   int          err_count = 0, n_compared = 0, cycles = 0, npulse = 0, base;
   // Register writes and read-backs with the expected response.
   row_t rows [9] = '{
      '{8'h00, 32'hFFFF_FFFF, 32'h0000_FFFF, 2'h0},
      '{8'h04, 32'h0000_A5A5, 32'h0000_A5A5, 2'h0},
      '{8'h0C, 32'hFFFF_FFFF, 32'h0000_00F0, 2'h0},
      '{8'h10, 32'hFFFF_FFFF, 32'h0000_000F, 2'h0},
      '{8'h18, 32'hFFFF_FFFF, 32'h0000_000F, 2'h0},
      '{8'h1C, 32'h0000_0002, 32'h0000_0002, 2'h0},
      '{8'h20, 32'hFFFF_FFFF, 32'h0000_FE00, 2'h0},
      '{8'h24, 32'hFFFF_FFFF, 32'h0000_0001, 2'h0},
      '{8'h28, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2}};

   gpio_ext_interrupt_pin_mux uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_pin_in(pin_in),
      .gpio_pin_out(pin_out), .gpio_pin_oe_n(oe_n), .pci_enable_strap(strap),
      .ext_irq_pulse(pulse), .irq(irq), .pci_reset_in(p_rst),
      .pci_clock_in(p_clk), .pci_grant_in(p_gnt), .pci_idsel_in(p_ids),
      .pci_byte_en3_in(p_cbe), .pci_byte_en3_out(1'b0),
      .pci_byte_en3_oe(1'b0), .pci_request_out(req), .pci_inta_assert(inta));

   board_model board (.pin_out(pin_out), .pin_oe_n(oe_n), .drive_en(den),
      .drive_lvl(dlvl), .pin_in(pin_in));

   // Clock, event counter and hang guard.
   always #10 aclk = ~aclk;
   always @(posedge aclk)
   begin
      npulse <= npulse + $countones(pulse);
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         err_count++;
         close_out();
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One register write; each channel is released once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   // One register read, holding rready until the data comes.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   // Waits a number of edges and lets their updates land.
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic done(input string name);
      $display("Finished test %s", name);
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Main sequence: reset, register table, then the awkward cases.
   initial
   begin
      idle(2);
      aresetn <= 1'b1;
      idle(1);
      chk(oe_n, 16'hFFFF);
      chk({p_rst, p_clk, p_gnt, p_ids, p_cbe, irq}, 6'h00);
      done("reset");
      for (int i = 0; i < 9; i++)
      begin
         wr(rows[i].a, rows[i].d);
         chk(rsp, rows[i].r);
         rd(rows[i].a, q);
         chk(q, rows[i].q);
         chk(rsp, rows[i].r);
      end
      wr(8'h10, 32'h0000_0005);
      wr(8'h14, 32'h0000_000F);
      idle(2);
      chk(oe_n, 16'h00F0);
      chk(pin_out & 16'hFF0E, 16'hA504);
      chk({pin_out[0], irq}, 2'b00);
      done("registers");
      // Pins 4 and 6 react to falling edges, pins 5 and 7 to rising ones.
      den[7:4]  <= 4'hF;
      dlvl[7:4] <= 4'hF;
      idle(6);
      wr(8'h14, 32'h0000_000F);
      base = npulse;
      dlvl[7:4] <= 4'h0;
      idle(8);
      rd(8'h14, q);
      chk(q, 32'h0000_0005);
      chk({irq, pin_out[0]}, 2'b11);
      dlvl[7:4] <= 4'hF;
      idle(20);
      rd(8'h14, q);
      chk(q, 32'h0000_000F);
      chk(npulse - base, 4);
      wr(8'h14, 32'h0000_0003);
      rd(8'h14, q);
      chk(q, 32'h0000_000C);
      wr(8'h18, 32'h0000_0003);
      idle(1);
      chk(irq, 1'b0);
      wr(8'h18, 32'h0000_000F);
      idle(1);
      chk(irq, 1'b1);
      wr(8'h14, 32'h0000_000C);
      idle(1);
      chk(irq, 1'b0);
      wr(8'h1C, 32'h0000_0001);
      idle(2);
      chk({oe_n[0], pin_out[0]}, 2'b01);
      done("interrupts");
      // Second reset with the strap set: PCI owns pins 9 to 15 once enabled.
      strap     <= 1'b1;
      aresetn   <= 1'b0;
      den[15]   <= 1'b1;
      dlvl[15]  <= 1'b1;
      idle(4);
      aresetn <= 1'b1;
      idle(8);
      chk({p_rst, oe_n}, 17'h0FFFF);
      wr(8'h24, 32'h0000_0001);
      rd(8'h24, q);
      chk(q, 32'h0000_0003);
      req        <= 1'b1;
      inta       <= 1'b1;
      den[14:9]  <= 6'h3F;
      dlvl[14:9] <= 6'h3F;
      idle(4);
      chk({pin_out[11], oe_n[11], oe_n[15], p_rst}, 4'hB);
      chk({oe_n[13], pin_out[13], oe_n[10]}, 3'b001);
      chk({p_clk, p_gnt, p_ids, p_cbe}, 4'hF);
      done("pci");
      close_out();
   end
endmodule

`default_nettype wire
